// ==== hw/isg_map_unit.sv ====
`default_nettype none
`include "isg_map.svh"
module isg_map_unit #(
    parameter int RAM_WORDS = 512
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // access from core and transfer controller
    input wire isg_pkg::isg_req_t req,
    output var isg_pkg::isg_rsp_t rsp,
    // status
    output var isg_pkg::isg_region_t region,
    output var isg_pkg::isg_stk_t stk,
    output logic [2:0] stack_size,
    output logic [15:0] context_base_pointer
);
    import isg_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] sz;
        logic [15:0] sp;
        logic [15:0] lim_lo;
        logic [15:0] lim_hi;
        logic [15:0] cp;
        isg_rsp_t rsp;
        isg_stk_t stk;
    } isg_state_t;

    isg_state_t s_q;
    isg_state_t s_d;
    logic [15:0] ram_q [RAM_WORDS];
    logic mem_we;
    logic [8:0] mem_idx;
    logic [15:0] mem_wdata;
    logic [23:0] phys;
    logic [15:0] offs;
    logic [15:0] word_rd;
    logic [15:0] sp_dec;
    logic [15:0] sp_word;
    logic [15:0] reg_val;
    logic [15:0] reg_wr;
    logic [15:0] gpr_off;
    logic stk_ovf_now;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] stk_bot(input logic [2:0] sz);
        case (sz)
            3'h1: stk_bot = `ISG_STK_BOT_1;
            3'h2: stk_bot = `ISG_STK_BOT_2;
            3'h3: stk_bot = `ISG_STK_BOT_3;
            3'h4: stk_bot = `ISG_STK_BOT_4;
            3'h7: stk_bot = `ISG_STK_BOT_7;
            default: stk_bot = `ISG_STK_BOT_0;
        endcase
    endfunction

    function automatic logic [15:0] stk_top(input logic [2:0] sz);
        stk_top = (sz == `ISG_SZ_MAX) ? `ISG_STK_TOP_MAX : `ISG_STK_TOP;
    endfunction

    function automatic logic [8:0] ram_index(input logic [15:0] a);
        logic [15:0] o;
        o = a - `ISG_RAM_LO;
        ram_index = o[9:1];
    endfunction

    function automatic logic in_ram(input logic [15:0] a);
        in_ram = (a >= `ISG_RAM_LO) && (a <= `ISG_RAM_HI);
    endfunction

    // ****************************************
    // address formation
    // ****************************************
    always_comb begin
        // byte registers overlay words: low at 2n, high at 2n+1
        if (req.is_byte) begin
            gpr_off = {12'h000, req.addr[3:0]};
        end else begin
            gpr_off = {11'h000, req.addr[3:0], 1'b0};
        end
    end

    always_comb begin
        if (req.short_gpr) begin
            phys = {8'h00, s_q.cp + gpr_off};
        end else if (req.event_transfer_controller || req.op == ISG_OP_FETCH) begin
            phys = req.event_transfer_controller ? {8'h00, req.addr[15:0]} : req.addr;
        end else begin
            phys = {req.data_page_pointer, req.addr[13:0]};
        end
    end

    isg_decode u_dec (
        .addr(phys),
        .region(region)
    );

    assign offs = phys[15:0];
    assign word_rd = ram_q[ram_index(offs)];
    assign sp_dec = s_q.sp - `ISG_WORD_STEP;
    assign sp_word = ram_q[ram_index(s_q.sp)];

    always_comb begin
        case (req.addr[3:1])
            `ISG_REG_CFG: reg_val = {s_q.sz, 13'h0000};
            `ISG_REG_SP: reg_val = s_q.sp;
            `ISG_REG_LO: reg_val = s_q.lim_lo;
            `ISG_REG_HI: reg_val = s_q.lim_hi;
            `ISG_REG_CP: reg_val = s_q.cp;
            default: reg_val = 16'h0000;
        endcase
    end

    // non-addressed byte forced to zero
    always_comb begin
        if (!req.is_byte) begin
            reg_wr = req.wdata;
        end else if (req.addr[0]) begin
            reg_wr = {req.wdata[7:0], 8'h00};
        end else begin
            reg_wr = {8'h00, req.wdata[7:0]};
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.rsp = '0;
        s_d.stk.ovf = 1'b0;
        s_d.stk.unf = 1'b0;
        s_d.stk.circ_ok = (s_q.sz != `ISG_SZ_MAX);
        mem_we = 1'b0;
        mem_idx = ram_index(offs);
        mem_wdata = word_rd;
        if (req.valid) begin
            s_d.rsp.valid = 1'b1;
            case (req.op)
                ISG_OP_RD: begin
                    if (!region.ram || (!req.is_byte && phys[0])) begin
                        s_d.rsp.err = 1'b1;
                    end else if (!req.is_byte) begin
                        s_d.rsp.rdata = word_rd;
                    end else if (phys[0]) begin
                        s_d.rsp.rdata = {8'h00, word_rd[15:8]};
                    end else begin
                        s_d.rsp.rdata = {8'h00, word_rd[7:0]};
                    end
                end
                ISG_OP_WR: begin
                    if (!region.ram || (!req.is_byte && phys[0])) begin
                        s_d.rsp.err = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        if (!req.is_byte) begin
                            mem_wdata = req.wdata;
                        end else if (phys[0]) begin
                            mem_wdata = {req.wdata[7:0], word_rd[7:0]};
                        end else begin
                            mem_wdata = {word_rd[15:8], req.wdata[7:0]};
                        end
                    end
                end
                ISG_OP_FETCH: begin
                    // is_byte marks a double-word fetch here
                    if (region.standard_register_block || region.extended_register_block) begin
                        s_d.rsp.err = 1'b1;
                    end else if (!region.ram || phys[0]) begin
                        s_d.rsp.err = 1'b1;
                    end else if (req.is_byte && offs > `ISG_CODE_DW_TOP) begin
                        s_d.rsp.err = 1'b1;
                    end else begin
                        s_d.rsp.rdata = word_rd;
                    end
                end
                ISG_OP_BSET, ISG_OP_BCLR: begin
                    // register bits outside this block are not held here
                    if (!(region.bit_ram || req.short_gpr) || !region.ram) begin
                        s_d.rsp.err = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_idx = ram_index(offs);
                        mem_wdata = word_rd;
                        mem_wdata[req.bit_idx] = (req.op == ISG_OP_BSET);
                        s_d.rsp.rdata = mem_wdata;
                    end
                end
                ISG_OP_PUSH, ISG_OP_CONTEXT_SWITCH_INSTRUCTION: begin
                    if (sp_dec < s_q.lim_lo || !in_ram(sp_dec)) begin
                        s_d.rsp.err = 1'b1;
                        s_d.stk.ovf = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_idx = ram_index(sp_dec);
                        mem_wdata = (req.op == ISG_OP_CONTEXT_SWITCH_INSTRUCTION) ? s_q.cp : req.wdata;
                        s_d.sp = sp_dec;
                        if (req.op == ISG_OP_CONTEXT_SWITCH_INSTRUCTION) begin
                            s_d.cp = {req.wdata[15:1], 1'b0};
                        end
                    end
                end
                ISG_OP_POP: begin
                    if (s_q.sp > s_q.lim_hi || !in_ram(s_q.sp)) begin
                        s_d.rsp.err = 1'b1;
                        s_d.stk.unf = 1'b1;
                    end else begin
                        s_d.rsp.rdata = sp_word;
                        s_d.sp = s_q.sp + `ISG_WORD_STEP;
                    end
                end
                ISG_OP_REG_RD: begin
                    s_d.rsp.rdata = reg_val;
                end
                ISG_OP_REG_WR: begin
                    case (req.addr[3:1])
                        `ISG_REG_CFG: begin
                            s_d.sz = reg_wr[`ISG_SZ_LSB+2:`ISG_SZ_LSB];
                            s_d.lim_lo = stk_bot(s_d.sz);
                            s_d.lim_hi = stk_top(s_d.sz);
                            s_d.sp = stk_top(s_d.sz) + `ISG_WORD_STEP;
                        end
                        // stack only handles words, so bit 0 is dropped
                        `ISG_REG_SP: s_d.sp = {reg_wr[15:1], 1'b0};
                        `ISG_REG_LO: s_d.lim_lo = {reg_wr[15:1], 1'b0};
                        `ISG_REG_HI: s_d.lim_hi = {reg_wr[15:1], 1'b0};
                        `ISG_REG_CP: s_d.cp = {reg_wr[15:1], 1'b0};
                        default: s_d.rsp.err = 1'b1;
                    endcase
                end
                default: begin
                    s_d.rsp.err = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q.sz <= `ISG_SZ_RST;
            s_q.sp <= `ISG_SP_RST;
            s_q.lim_lo <= `ISG_STK_BOT_0;
            s_q.lim_hi <= `ISG_STK_TOP;
            s_q.cp <= `ISG_CP_RST;
            s_q.rsp <= '0;
            s_q.stk <= 3'b001;
        end else begin
            s_q <= s_d;
        end
    end

    // ram contents are not reset, as in the real array
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            ram_q[mem_idx] <= mem_wdata;
        end
    end

    assign rsp = s_q.rsp;
    assign stk = s_q.stk;
    assign stack_size = s_q.sz;
    assign context_base_pointer = s_q.cp;

    // ****************************************
    // checks
    // ****************************************
    a_rsp_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid |=> rsp.valid) else $error("no answer one cycle after request");

    a_fetch_reg_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_FETCH && (region.standard_register_block || region.extended_register_block) |=> rsp.err)
        else $error("fetch from register block not refused");

    a_odd_word_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_RD && !req.is_byte && phys[0] |=> rsp.err)
        else $error("odd word read not refused");

    a_page_three_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_RD && !req.short_gpr && !req.event_transfer_controller
        && req.data_page_pointer != `ISG_RAM_PAGE |=> rsp.err)
        else $error("ram reached without page 3");

    a_reset_stack: assert property (@(posedge clk_sys)
        !rst_b |=> stack_size == 3'h0 && s_q.lim_lo == 16'hfa00 && s_q.lim_hi == 16'hfbfe)
        else $error("reset stack size wrong");

    a_push_down: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_PUSH && !stk_ovf_now
        |=> s_q.sp == $past(s_q.sp) - 16'h0002 && !rsp.err)
        else $error("push did not lower stack pointer by one word");

    a_push_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_PUSH && stk_ovf_now
        |=> stk.ovf && $stable(s_q.sp))
        else $error("push past lower limit not flagged");

    a_ctx_switch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_CONTEXT_SWITCH_INSTRUCTION && !stk_ovf_now
        |=> context_base_pointer == {$past(req.wdata[15:1]), 1'b0}
        && ram_q[ram_index(s_q.sp)] == $past(s_q.cp))
        else $error("context switch did not load and save");

    a_byte_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_REG_WR && req.is_byte && req.addr[0]
        && req.addr[3:1] == `ISG_REG_CP |=> context_base_pointer[7:0] == 8'h00)
        else $error("byte write did not clear other byte");

    a_cfg_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_REG_RD && req.addr[3:1] == `ISG_REG_CFG
        |=> rsp.rdata[12:0] == 13'h0000)
        else $error("reserved configuration bits not zero");

    a_big_stack: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req.valid && req.op == ISG_OP_REG_WR && !req.is_byte && req.addr[3:1] == `ISG_REG_CFG
        && req.wdata[15:13] == 3'h7
        |=> s_q.lim_hi == 16'hfdfe && s_q.lim_lo == 16'hf600 ##1 !stk.circ_ok)
        else $error("1024-word stack limits wrong");

    assign stk_ovf_now = (sp_dec < s_q.lim_lo) || !in_ram(sp_dec);
endmodule // isg_map_unit
`default_nettype wire

// ==== hw/isg_map.svh ====
`ifndef ISG_MAP_SVH
`define ISG_MAP_SVH
// ****************************************
// address map
// ****************************************
`define ISG_AREA_TAG 12'h00f
`define ISG_EXTENDED_REGISTER_BLOCK_LO 16'hf000
`define ISG_EXTENDED_REGISTER_BLOCK_HI 16'hf1ff
`define ISG_EXTENDED_REGISTER_BLOCK_BIT 16'hf100
`define ISG_RAM_LO 16'hfa00
`define ISG_RAM_HI 16'hfdff
`define ISG_RAM_WTOP 16'hfdfe
`define ISG_CODE_DW_TOP 16'hfdfc
`define ISG_PEC_LO 16'hfce0
`define ISG_PEC_HI 16'hfcff
`define ISG_RAM_BIT 16'hfd00
`define ISG_SFR_LO 16'hfe00
`define ISG_SFR_BIT 16'hff00
`define ISG_RAM_PAGE 10'h003
// ****************************************
// stack and register bank
// ****************************************
`define ISG_STK_TOP 16'hfbfe
`define ISG_STK_TOP_MAX 16'hfdfe
`define ISG_STK_BOT_0 16'hfa00
`define ISG_STK_BOT_1 16'hfb00
`define ISG_STK_BOT_2 16'hfb80
`define ISG_STK_BOT_3 16'hfbc0
`define ISG_STK_BOT_4 16'hf800
`define ISG_STK_BOT_7 16'hf600
`define ISG_SZ_MAX 3'h7
`define ISG_SZ_RST 3'h0
`define ISG_SZ_LSB 13
`define ISG_SP_RST 16'hfc00
`define ISG_CP_RST 16'hfc00
`define ISG_WORD_STEP 16'h0002
// ****************************************
// local register index (addr[3:1])
// ****************************************
`define ISG_REG_CFG 3'h0
`define ISG_REG_SP 3'h1
`define ISG_REG_LO 3'h2
`define ISG_REG_HI 3'h3
`define ISG_REG_CP 3'h4
`endif

// ==== hw/isg_pkg.sv ====
`default_nettype none
package isg_pkg;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        ISG_OP_RD = 4'h0,
        ISG_OP_WR = 4'h1,
        ISG_OP_FETCH = 4'h3,
        ISG_OP_BSET = 4'h2,
        ISG_OP_BCLR = 4'h6,
        ISG_OP_PUSH = 4'h7,
        ISG_OP_POP = 4'h5,
        ISG_OP_CONTEXT_SWITCH_INSTRUCTION = 4'h4,
        ISG_OP_REG_RD = 4'hc,
        ISG_OP_REG_WR = 4'hd
    } isg_op_t;

    typedef struct packed {
        logic valid;
        isg_op_t op;
        logic is_byte;
        logic short_gpr;
        logic event_transfer_controller;
        logic [3:0] bit_idx;
        logic [23:0] addr;
        logic [9:0] data_page_pointer;
        logic [15:0] wdata;
    } isg_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } isg_rsp_t;

    typedef struct packed {
        logic area;
        logic ram;
        logic event_transfer_controller;
        logic bit_ram;
        logic standard_register_block;
        logic extended_register_block;
        logic sfr_bit;
        logic extended_register_block_bit;
    } isg_region_t;

    typedef struct packed {
        logic ovf;
        logic unf;
        logic circ_ok;
    } isg_stk_t;
endpackage
`default_nettype wire

// ==== hw/isg_decode.sv ====
`default_nettype none
`include "isg_map.svh"
module isg_decode (
    // physical address
    input wire logic [23:0] addr,
    // decoded region
    output var isg_pkg::isg_region_t region
);
    import isg_pkg::*;
    logic [15:0] a;
    logic in_area;
    assign a = addr[15:0];
    assign in_area = (addr[23:12] == `ISG_AREA_TAG);
    always_comb begin
        region = '0;
        region.area = in_area;
        region.ram = in_area && (a >= `ISG_RAM_LO) && (a <= `ISG_RAM_HI);
        region.event_transfer_controller = in_area && (a >= `ISG_PEC_LO) && (a <= `ISG_PEC_HI);
        region.standard_register_block = in_area && (a >= `ISG_SFR_LO);
        region.extended_register_block = in_area && (a >= `ISG_EXTENDED_REGISTER_BLOCK_LO) && (a <= `ISG_EXTENDED_REGISTER_BLOCK_HI);
        // upper 256 bytes of each block take single bits
        region.bit_ram = region.ram && (a >= `ISG_RAM_BIT);
        region.sfr_bit = region.standard_register_block && (a >= `ISG_SFR_BIT);
        region.extended_register_block_bit = region.extended_register_block && (a >= `ISG_EXTENDED_REGISTER_BLOCK_BIT);
    end
endmodule // isg_decode
`default_nettype wire

// ==== dv/isg_core_model.sv ====
`default_nettype none
module isg_core_model (
    // clock
    input wire logic clk_sys,
    // command from bench
    input wire isg_pkg::isg_req_t cmd,
    input wire logic go,
    // request to the map unit
    output var isg_pkg::isg_req_t req
);
    import isg_pkg::*;
    isg_req_t req_q;
    // ****************************************
    // request driver
    // ****************************************
    // idle fields toggle so a stale value never reads as live
    always_ff @(posedge clk_sys) begin
        if (go) begin
            req_q <= cmd;
        end else begin
            req_q <= {1'b0, ~req_q[$bits(isg_req_t)-2:0]};
        end
    end
    assign req = req_q;
endmodule // isg_core_model
`default_nettype wire

// ==== dv/isg_map_unit_tb.sv ====
`default_nettype none
`include "isg_map.svh"
module isg_map_unit_tb;
    import isg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] FB = 3'b100;
    localparam logic [2:0] FS = 3'b010;
    localparam logic [2:0] FP = 3'b001;
    logic clk_sys, rst_b, go;
    logic [9:0] dpp_v;
    int num_errors = 0;
    int checked = 0;
    isg_req_t cmd, req;
    isg_rsp_t rsp, r;
    isg_region_t region;
    isg_stk_t stk, s;
    logic [2:0] stack_size;
    logic [15:0] context_base_pointer;
    logic [23:0] fa [7] = '{24'h00fe00, 24'h00f000, 24'h00fdfc, 24'h00fdfe, 24'h00fdfe,
        24'h00fa01, 24'h01fa00};
    logic [6:0] fdw = 7'b0011000;
    logic [6:0] ferr = 7'b1101011;
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    logic [15:0] bot [8] = '{16'hfa00, 16'hfb00, 16'hfb80, 16'hfbc0, 16'hf800, 16'hfa00,
        16'hfa00, 16'hf600};
    logic [15:0] top;
    isg_core_model u_core (.clk_sys(clk_sys), .cmd(cmd), .go(go), .req(req));
    isg_map_unit #(.RAM_WORDS(512)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
        .rsp(rsp), .region(region), .stk(stk), .stack_size(stack_size),
        .context_base_pointer(context_base_pointer));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input isg_op_t op, input logic [23:0] a, input logic [15:0] d,
        input logic [2:0] f, input logic [3:0] bi);
        isg_req_t c;
        c = '0;
        c.valid = 1'b1;
        c.op = op;
        {c.is_byte, c.short_gpr, c.event_transfer_controller} = f;
        c.bit_idx = bi;
        c.addr = a;
        c.data_page_pointer = dpp_v;
        c.wdata = d;
        @(posedge clk_sys);
        cmd <= c;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        r = '0;
        // answer is one cycle after taking; four edges is ample margin
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            #1;
            if (rsp.valid === 1'b1) begin
                r = rsp;
                s = stk;
                break;
            end
        end
        chk("rsp_valid", 16'h0001, r.valid);
    endtask
    task automatic rreg(input logic [2:0] idx, input logic [15:0] exp, input string nm);
        acc(ISG_OP_REG_RD, {20'h0, idx, 1'b0}, 16'h0000, 3'b000, 4'h0);
        chk(nm, exp, r.rdata);
    endtask
    task automatic summarize();
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        go = 1'b0;
        cmd = '0;
        dpp_v = 10'h003;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("size_rst", 16'h0000, stack_size);
        chk("cp_rst", 16'hfc00, context_base_pointer);
        chk("stk_rst", 16'h0001, stk);
        rreg(`ISG_REG_LO, 16'hfa00, "lo_rst");
        acc(ISG_OP_WR, 24'h003a00, 16'ha55a, 3'b000, 4'h0);
        acc(ISG_OP_RD, 24'h003a00, 16'h0000, 3'b000, 4'h0);
        chk("rd_word", 16'ha55a, r.rdata);
        acc(ISG_OP_RD, 24'h003a01, 16'h0000, FB, 4'h0);
        chk("rd_hi", 16'h00a5, r.rdata);
        acc(ISG_OP_RD, 24'h003a01, 16'h0000, 3'b000, 4'h0);
        chk("odd_word", 16'h0001, r.err);
        acc(ISG_OP_RD, 24'h003e00, 16'h0000, 3'b000, 4'h0);
        chk("sfr_data", 16'h0001, r.err);
        dpp_v = 10'h002;
        acc(ISG_OP_RD, 24'h003a00, 16'h0000, 3'b000, 4'h0);
        chk("dpp2_rd", 16'h0001, r.err);
        acc(ISG_OP_WR, 24'h00fce2, 16'h1357, FP, 4'h0);
        acc(ISG_OP_RD, 24'h00fce2, 16'h0000, FP, 4'h0);
        chk("pec_rd", 16'h1357, r.rdata);
        dpp_v = 10'h003;
        acc(ISG_OP_RD, 24'h003ce2, 16'h0000, 3'b000, 4'h0);
        chk("pec_ram", 16'h1357, r.rdata);
        acc(ISG_OP_FETCH, 24'h00fa00, 16'h0000, 3'b000, 4'h0);
        chk("fetch_ram", 16'ha55a, r.rdata);
        for (int i = 0; i < 7; i++) begin
            acc(ISG_OP_FETCH, fa[i], 16'h0000, fdw[6-i] ? FB : 3'b000, 4'h0);
            chk("fetch_err", {15'h0, ferr[6-i]}, r.err);
        end
        acc(ISG_OP_WR, 24'h003d00, 16'h0000, 3'b000, 4'h0);
        acc(ISG_OP_BSET, 24'h003d00, 16'h0000, 3'b000, 4'hf);
        acc(ISG_OP_RD, 24'h003d00, 16'h0000, 3'b000, 4'h0);
        chk("bit15", 16'h8000, r.rdata);
        acc(ISG_OP_BCLR, 24'h003d00, 16'h0000, 3'b000, 4'hf);
        acc(ISG_OP_BSET, 24'h003d00, 16'h0000, 3'b000, 4'h0);
        acc(ISG_OP_RD, 24'h003d00, 16'h0000, 3'b000, 4'h0);
        chk("bit0", 16'h0001, r.rdata);
        acc(ISG_OP_BSET, 24'h003a00, 16'h0000, 3'b000, 4'h0);
        chk("bit_low", 16'h0001, r.err);
        acc(ISG_OP_PUSH, 24'h000000, 16'h1234, 3'b000, 4'h0);
        rreg(`ISG_REG_SP, 16'hfbfe, "sp_push");
        acc(ISG_OP_POP, 24'h000000, 16'h0000, 3'b000, 4'h0);
        chk("pop", 16'h1234, r.rdata);
        acc(ISG_OP_POP, 24'h000000, 16'h0000, 3'b000, 4'h0);
        chk("unf", 16'h0003, {r.err, s.unf});
        // reserved codes 101 and 110 are never written
        for (int i = 0; i < 6; i++) begin
            top = (codes[i] == 3'h7) ? 16'hfdfe : 16'hfbfe;
            acc(ISG_OP_REG_WR, 24'h000000, {codes[i], 13'h0}, 3'b000, 4'h0);
            chk("size", {13'h0, codes[i]}, stack_size);
            rreg(`ISG_REG_LO, bot[codes[i]], "lo");
            chk("circ", {15'h0, codes[i] != 3'h7}, stk.circ_ok);
            rreg(`ISG_REG_HI, top, "hi");
            rreg(`ISG_REG_SP, top + 16'h0002, "sp");
            rreg(`ISG_REG_CFG, {codes[i], 13'h0}, "cfg");
        end
        acc(ISG_OP_REG_WR, 24'h00000a, 16'h0000, 3'b000, 4'h0);
        chk("reg5", 16'h0001, r.err);
        acc(ISG_OP_REG_WR, 24'h000004, 16'hf9fe, 3'b000, 4'h0);
        acc(ISG_OP_REG_WR, 24'h000005, 16'h00fa, FB, 4'h0);
        rreg(`ISG_REG_LO, 16'hfa00, "lane");
        acc(ISG_OP_REG_WR, 24'h000000, 16'h0000, 3'b000, 4'h0);
        acc(ISG_OP_CONTEXT_SWITCH_INSTRUCTION, 24'h000000, 16'hfa20, 3'b000, 4'h0);
        chk("cp_new", 16'hfa20, context_base_pointer);
        acc(ISG_OP_POP, 24'h000000, 16'h0000, 3'b000, 4'h0);
        chk("cp_saved", 16'hfc00, r.rdata);
        acc(ISG_OP_WR, 24'h00000f, 16'hbeef, FS, 4'h0);
        acc(ISG_OP_RD, 24'h003a3e, 16'h0000, 3'b000, 4'h0);
        chk("r15", 16'hbeef, r.rdata);
        acc(ISG_OP_WR, 24'h000001, 16'h0000, FS, 4'h0);
        acc(ISG_OP_WR, 24'h000003, 16'h0077, FB | FS, 4'h0);
        acc(ISG_OP_BSET, 24'h000001, 16'h0000, FS, 4'h0);
        acc(ISG_OP_RD, 24'h003a22, 16'h0000, 3'b000, 4'h0);
        chk("r1", 16'h7701, r.rdata);
        acc(ISG_OP_REG_WR, 24'h000004, 16'hfbfe, 3'b000, 4'h0);
        acc(ISG_OP_PUSH, 24'h000000, 16'h5555, 3'b000, 4'h0);
        chk("push_ok", 16'h0000, r.err);
        acc(ISG_OP_PUSH, 24'h000000, 16'h6666, 3'b000, 4'h0);
        chk("ovf", 16'h0003, {r.err, s.ovf});
        acc(ISG_OP_REG_WR, 24'h000009, 16'h00fb, FB, 4'h0);
        chk("cp_lane", 16'hfb00, context_base_pointer);
        summarize();
    end
endmodule // isg_map_unit_tb
`default_nettype wire
